//--- src/drive_output_pkg.sv
package drive_output_pkg;

  // Output count and selector width
  localparam int NUM_OUTPUTS = 4;
  localparam int SEL_WIDTH = 6;
  localparam int SRC_COUNT = 64;

  // Selector codes for the functions this block serves
  localparam logic [5:0] SEL_LIMIT = 6'h0E;
  localparam logic [5:0] SEL_REACHED = 6'h0F;
  localparam logic [5:0] SEL_ROT_CW = 6'h10;
  localparam logic [5:0] SEL_ROT_CCW = 6'h11;
  localparam logic [5:0] SEL_CONTACTOR = 6'h20;
  localparam logic [5:0] SEL_CONTACTOR_INV = 6'h21;
  localparam logic [5:0] SEL_CAM_FIRST = 6'h2E;
  localparam logic [5:0] SEL_CAM_LAST = 6'h3A;
  localparam logic [5:0] SEL_BRAKE_ONE_INV = 6'h3B;
  localparam logic [5:0] SEL_BRAKE_TWO_INV = 6'h3C;

  // Cam point numbering: selector SEL_CAM_FIRST shows point four
  localparam int CAM_POINTS = 16;
  localparam int CAM_FIRST_POINT = 4;

  // Clock and contactor delay timing
  localparam int CLOCK_HZ = 25_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLOCK_HZ / MS_PER_S;
  localparam int DELAY_WIDTH = 11;
  localparam logic [10:0] DELAY_MAX_MS = 11'h7D0;
  localparam logic [10:0] DELAY_DEFAULT_MS = 11'h12C;
  localparam logic [10:0] DELAY_OFF_MS = 11'h000;

  // Fixed point: scale and factors are Q8, 9'h100 is unity
  localparam int TORQUE_PROD_LSB = 16;
  localparam int SPEED_PROD_LSB = 8;

  // Control modes of the drive
  typedef enum logic [1:0] {
    mode_torque,
    mode_speed,
    mode_position,
    mode_endless
  } control_mode_type;

  // Contactor sequencer states
  typedef enum logic [1:0] {
    st_open,
    st_making,
    st_closed,
    st_breaking
  } contactor_state_type;

  // Live drive values
  typedef struct packed {
    control_mode_type mode;
    logic signed [15:0] torque_ref;
    logic signed [15:0] torque_act;
    logic signed [15:0] speed_ref;
    logic signed [15:0] speed_act;
    logic signed [31:0] position_act;
    logic signed [31:0] position_target;
  } drive_values_type;

  // Limit parameters
  typedef struct packed {
    logic [8:0] torque_scale;
    logic [8:0] torque_limit_factor;
    logic [8:0] max_speed_factor;
    logic [15:0] rated_motor_torque;
    logic [15:0] rated_motor_speed;
  } limit_params_type;

endpackage

//--- src/output_function_mux.sv
`timescale 1ns/1ps
// One digital output: picks its source by selector and registers it
module output_function_mux
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [drive_output_pkg::SEL_WIDTH-1:0] selector,
  input wire logic [drive_output_pkg::SRC_COUNT-1:0] sources,
  output logic out_r
);

  // Unused selector codes index sources held at zero
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      out_r <= 1'b0;
    else
      out_r <= sources[selector];
  end

endmodule

//--- src/drive_output_function_contactor.sv
`timescale 1ns/1ps
// Operation
// - Selectors 46..58 show cam points 4..16
// - Selector 59 shows brake one inverted
// - Selector 60 shows brake two inverted
// - Limit output set while setpoint exceeds maximum
// - Torque mode: torque reference above scaled maximum
// - Speed mode: speed reference above scaled maximum
// - Positioning: either speed or torque over maximum
// - Reached while deviation within mode window
// - Position reached only at final target
// - Reached compares torque, speed per mode
// - Rotation outputs use the reached window
// - Contactor closed around power stage release
// - Setpoint released only after contactor delay
// - Zero delay disables contactor control
// - Contactor closes during self-setting
// - Control active when any selector picks contactor
// - Delay programmable 0..2000 ms, default 300
// - Overcurrent error suppressed without power release
// - Selector 32: contactor, held for delay
// - Selector 33: inverted contactor function
module drive_output_function_contactor
#(
  // Cycles per millisecond, shortened in simulation
  parameter int CYCLES_PER_MS = drive_output_pkg::MS_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rstn,
  // Per-output function selectors
  input wire logic [drive_output_pkg::NUM_OUTPUTS-1:0][5:0]
    output_function_selector,
  // Cam switching points 1..16, bit 0 is point 1
  input wire logic [drive_output_pkg::CAM_POINTS-1:0] cam_points,
  input wire logic brake_one,
  input wire logic brake_two,
  input wire drive_output_pkg::drive_values_type drive_values,
  input wire drive_output_pkg::limit_params_type limit_params,
  input wire logic [15:0] reached_window,
  input wire logic [31:0] reached_window_positioning,
  // Contactor delay in ms
  input wire logic [10:0] contactor_delay,
  input wire logic start_request,
  input wire logic autotune_active,
  input wire logic overcurrent_detect,
  input wire logic overcurrent_clear,
  // Hardware power release pin, asynchronous
  input wire logic hardware_power_release,
  output logic [drive_output_pkg::NUM_OUTPUTS-1:0] digital_outputs,
  output logic limit_flag_r,
  output logic setpoint_reached_r,
  output logic clockwise_rotation_r,
  output logic anticlockwise_rotation_r,
  output logic contactor_closed_r,
  output logic power_stage_release_r,
  output logic overcurrent_error_one_r
);

  // Magnitude of a 16-bit signed value, one bit wider
  function automatic logic [16:0] mag16(input logic signed [16:0] v);
    logic [16:0] r;
    r = v[16] ? 17'(-v) : 17'(v);
    return r;
  endfunction

  // Magnitude of a 32-bit difference, one bit wider
  function automatic logic [32:0] mag32(input logic signed [32:0] v);
    logic [32:0] r;
    r = v[32] ? 33'(-v) : 33'(v);
    return r;
  endfunction

  // Power release pin synchroniser, three stages
  logic hardware_power_release_s1_r;
  logic hardware_power_release_s2_r;
  logic hardware_power_release_s3_r;
  logic hardware_power_release_ok_r; // Filtered release level

  // Contactor sequencer
  drive_output_pkg::contactor_state_type state_r;
  drive_output_pkg::contactor_state_type state_nxt;
  logic [15:0] prescale_r; // Cycles within the current ms
  logic [10:0] ms_count_r; // Whole ms since timer load
  logic ctl_active_r; // Contactor control enabled

  // Named decode wires
  wire logic ctl_active_nxt;
  wire logic run_demand;
  wire logic [10:0] delay_eff;
  wire logic timer_done;
  wire logic timer_load;
  wire logic ms_tick;
  wire logic contactor_nxt;
  wire logic power_nxt;
  wire logic overcurrent_nxt;
  wire logic [drive_output_pkg::NUM_OUTPUTS-1:0] pick_contactor;

  // Limit arithmetic
  wire logic [33:0] torque_prod;
  wire logic [24:0] speed_prod;
  wire logic [17:0] max_torque;
  wire logic [16:0] max_speed;
  wire logic torque_over;
  wire logic speed_over;
  logic limit_nxt;

  // Reached and rotation arithmetic
  wire logic [16:0] torque_dev;
  wire logic [16:0] speed_dev;
  wire logic [32:0] position_dev;
  logic reached_nxt;
  wire logic cw_nxt;
  wire logic ccw_nxt;

  // Source vector indexed by selector code
  logic [drive_output_pkg::SRC_COUNT-1:0] sources;

  // Three-stage synchroniser; only agreeing stages move the level
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hardware_power_release_s1_r <= 1'b0;
      hardware_power_release_s2_r <= 1'b0;
      hardware_power_release_s3_r <= 1'b0;
      hardware_power_release_ok_r <= 1'b0;
    end
    else
    begin
      hardware_power_release_s1_r <= hardware_power_release;
      hardware_power_release_s2_r <= hardware_power_release_s1_r;
      hardware_power_release_s3_r <= hardware_power_release_s2_r;
      if (hardware_power_release_s2_r == hardware_power_release_s3_r)
        hardware_power_release_ok_r <= hardware_power_release_s3_r;
    end
  end

  // Any output on the contactor function enables control
  genvar g;
  generate
    for (g = 0; g < drive_output_pkg::NUM_OUTPUTS; g++)
    begin : g_pick
      assign pick_contactor[g] =
        (output_function_selector[g] == drive_output_pkg::SEL_CONTACTOR) ||
        (output_function_selector[g] ==
         drive_output_pkg::SEL_CONTACTOR_INV);
    end
  endgenerate

  // A zero delay turns the whole function off
  assign ctl_active_nxt = (|pick_contactor) &&
    (contactor_delay != drive_output_pkg::DELAY_OFF_MS);

  // Out-of-range delays clamp to the top of the range
  assign delay_eff = (contactor_delay > drive_output_pkg::DELAY_MAX_MS) ?
    drive_output_pkg::DELAY_MAX_MS : contactor_delay;

  // Self-setting needs the motor connected just like a start
  assign run_demand = start_request || autotune_active;

  // Delay timer decode
  assign ms_tick = (prescale_r == 16'(CYCLES_PER_MS - 1));
  assign timer_done = (ms_count_r >= delay_eff);
  assign timer_load = (state_nxt != state_r);

  // Sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      drive_output_pkg::st_open:
        if (run_demand && ctl_active_r)
          state_nxt = drive_output_pkg::st_making;
      drive_output_pkg::st_making:
        // Hold off the power stage until the contacts settle
        if (!ctl_active_r)
          state_nxt = drive_output_pkg::st_open;
        else if (!run_demand)
          state_nxt = drive_output_pkg::st_breaking;
        else if (timer_done)
          state_nxt = drive_output_pkg::st_closed;
      drive_output_pkg::st_closed:
        if (!ctl_active_r)
          state_nxt = drive_output_pkg::st_open;
        else if (!run_demand)
          state_nxt = drive_output_pkg::st_breaking;
      drive_output_pkg::st_breaking:
        // Contacts stay closed while the stage winds down
        if (!ctl_active_r)
          state_nxt = drive_output_pkg::st_open;
        else if (run_demand)
          state_nxt = drive_output_pkg::st_making;
        else if (timer_done)
          state_nxt = drive_output_pkg::st_open;
    endcase
  end

  // Contactor closed in every state but open
  assign contactor_nxt =
    (state_nxt != drive_output_pkg::st_open);
  // Stage only in closed; held off as control arms; else follows demand
  assign power_nxt = (ctl_active_r || ctl_active_nxt) ?
    (state_nxt == drive_output_pkg::st_closed) : run_demand;

  // Sequencer registers
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= drive_output_pkg::st_open;
      ctl_active_r <= 1'b0;
      contactor_closed_r <= 1'b0;
      power_stage_release_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      ctl_active_r <= ctl_active_nxt;
      contactor_closed_r <= contactor_nxt;
      power_stage_release_r <= power_nxt;
    end
  end

  // Millisecond timer, restarted on every state change
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prescale_r <= 16'h0000;
      ms_count_r <= 11'h000;
    end
    else if (timer_load)
    begin
      prescale_r <= 16'h0000;
      ms_count_r <= 11'h000;
    end
    else if (ms_tick)
    begin
      prescale_r <= 16'h0000;
      // Saturate so a long stay cannot wrap to not-done
      if (!timer_done)
        ms_count_r <= ms_count_r + 11'h001;
    end
    else
      prescale_r <= prescale_r + 16'h0001;
  end

  // Overcurrent only counts with the power release present;
  // without it the trip is taken as an intended contactor switch.
  // A new trip wins over a clear in the same cycle.
  assign overcurrent_nxt = (overcurrent_detect && hardware_power_release_ok_r) ||
    (overcurrent_error_one_r && !overcurrent_clear);

  // Maximum torque: scale x factor x rated torque, Q8 x Q8
  assign torque_prod = 34'(limit_params.torque_scale) *
    34'(limit_params.torque_limit_factor) *
    34'(limit_params.rated_motor_torque);
  assign max_torque =
    torque_prod[33:drive_output_pkg::TORQUE_PROD_LSB];
  // Maximum speed: factor x rated speed, Q8
  assign speed_prod = 25'(limit_params.max_speed_factor) *
    25'(limit_params.rated_motor_speed);
  assign max_speed =
    speed_prod[24:drive_output_pkg::SPEED_PROD_LSB];

  // Reference magnitudes against the maxima
  assign torque_over = ({1'b0, mag16(17'(drive_values.torque_ref))} >
    max_torque);
  assign speed_over = (mag16(17'(drive_values.speed_ref)) >
    max_speed);

  // Limit per mode
  always_comb
  begin
    limit_nxt = 1'b0;
    unique case (drive_values.mode)
      drive_output_pkg::mode_torque:
        limit_nxt = torque_over;
      drive_output_pkg::mode_speed:
        limit_nxt = speed_over;
      drive_output_pkg::mode_position,
      drive_output_pkg::mode_endless:
        limit_nxt = speed_over || torque_over;
    endcase
  end

  // Deviations of actual from setpoint
  assign torque_dev = mag16(17'(drive_values.torque_act) -
    17'(drive_values.torque_ref));
  assign speed_dev = mag16(17'(drive_values.speed_act) -
    17'(drive_values.speed_ref));
  // Compared with the final target so a halt never reports reached
  assign position_dev = mag32(33'(drive_values.position_target) -
    33'(drive_values.position_act));

  // Reached per mode
  always_comb
  begin
    reached_nxt = 1'b0;
    unique case (drive_values.mode)
      drive_output_pkg::mode_torque:
        reached_nxt = (torque_dev <= {1'b0, reached_window});
      drive_output_pkg::mode_speed,
      drive_output_pkg::mode_endless:
        reached_nxt = (speed_dev <= {1'b0, reached_window});
      drive_output_pkg::mode_position:
        reached_nxt = (position_dev <=
          {1'b0, reached_window_positioning});
    endcase
  end

  // Rotation sense needs the speed outside the reached window
  assign cw_nxt = ($signed(17'(drive_values.speed_act)) >
    $signed({1'b0, reached_window}));
  assign ccw_nxt = ($signed(17'(drive_values.speed_act)) <
    -$signed({1'b0, reached_window}));

  // Status registers
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      limit_flag_r <= 1'b0;
      setpoint_reached_r <= 1'b0;
      clockwise_rotation_r <= 1'b0;
      anticlockwise_rotation_r <= 1'b0;
      overcurrent_error_one_r <= 1'b0;
    end
    else
    begin
      limit_flag_r <= limit_nxt;
      setpoint_reached_r <= reached_nxt;
      clockwise_rotation_r <= cw_nxt;
      anticlockwise_rotation_r <= ccw_nxt;
      overcurrent_error_one_r <= overcurrent_nxt;
    end
  end

  // Next-value sources so outputs lag their cause by one cycle
  always_comb
  begin
    sources = '0;
    sources[drive_output_pkg::SEL_LIMIT] = limit_nxt;
    sources[drive_output_pkg::SEL_REACHED] = reached_nxt;
    sources[drive_output_pkg::SEL_ROT_CW] = cw_nxt;
    sources[drive_output_pkg::SEL_ROT_CCW] = ccw_nxt;
    sources[drive_output_pkg::SEL_CONTACTOR] = contactor_nxt;
    sources[drive_output_pkg::SEL_CONTACTOR_INV] =
      !contactor_nxt;
    for (int k = 0; k <= int'(drive_output_pkg::SEL_CAM_LAST -
         drive_output_pkg::SEL_CAM_FIRST); k++)
      sources[int'(drive_output_pkg::SEL_CAM_FIRST) + k] =
        cam_points[drive_output_pkg::CAM_FIRST_POINT - 1 + k];
    sources[drive_output_pkg::SEL_BRAKE_ONE_INV] = !brake_one;
    sources[drive_output_pkg::SEL_BRAKE_TWO_INV] = !brake_two;
  end

  // One registered selector stage per output
  generate
    for (g = 0; g < drive_output_pkg::NUM_OUTPUTS; g++)
    begin : g_out
      output_function_mux u_mux
      (
        .core_clk(core_clk),
        .rstn(rstn),
        .selector(output_function_selector[g]),
        .sources(sources),
        .out_r(digital_outputs[g])
      );
    end
  endgenerate

  // Checks on the selector outputs, the status flags and the sequencer
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  a_cam_point_four: assert property (
    (output_function_selector[0] == drive_output_pkg::SEL_CAM_FIRST)
    |=> (digital_outputs[0] == $past(cam_points[3])))
    else $error("cam point four not shown");

  a_brake_one_inv: assert property (
    (output_function_selector[1] == drive_output_pkg::SEL_BRAKE_ONE_INV)
    |=> (digital_outputs[1] != $past(brake_one)))
    else $error("brake one not inverted");

  a_brake_two_inv: assert property (
    (output_function_selector[2] == drive_output_pkg::SEL_BRAKE_TWO_INV)
    |=> (digital_outputs[2] != $past(brake_two)))
    else $error("brake two not inverted");

  a_limit_torque: assert property (
    (drive_values.mode == drive_output_pkg::mode_torque) && torque_over
    |=> limit_flag_r)
    else $error("torque limit missed");

  a_limit_speed: assert property (
    (drive_values.mode == drive_output_pkg::mode_speed) && !speed_over
    |=> !limit_flag_r)
    else $error("speed limit false");

  a_power_needs_contactor: assert property (
    ctl_active_r && power_stage_release_r |-> contactor_closed_r)
    else $error("power stage released with contactor open");

  a_release_after_making: assert property (
    $rose(power_stage_release_r) && $past(ctl_active_r)
    |-> $past(contactor_closed_r, 2))
    else $error("release without contactor making");

  a_zero_delay_off: assert property (
    (contactor_delay == drive_output_pkg::DELAY_OFF_MS)
    |=> ##1 (state_r == drive_output_pkg::st_open))
    else $error("control active with zero delay");

  a_oc_suppressed: assert property (
    $rose(overcurrent_error_one_r) |-> $past(hardware_power_release_ok_r))
    else $error("overcurrent raised without release");

  a_rotation_exclusive: assert property (
    !(clockwise_rotation_r && anticlockwise_rotation_r))
    else $error("both rotation senses");

  c_making: cover property (
    state_r == drive_output_pkg::st_making ##1
    state_r == drive_output_pkg::st_closed);
  c_breaking: cover property (
    state_r == drive_output_pkg::st_breaking ##1
    state_r == drive_output_pkg::st_open);
  c_oc_suppress: cover property (overcurrent_detect && !hardware_power_release_ok_r);
  c_reached: cover property ($rose(setpoint_reached_r));

endmodule

//--- test/contactor_model.sv
`timescale 1ns/1ps
// Motor contactor on the far side: contacts follow the coil late
module contactor_model
#(
  // Pickup and dropout time in clock cycles
  parameter int SWITCH_CYCLES = 3
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic coil,
  input wire logic power_release,
  input wire logic watch,
  output logic contacts_r,
  output logic [7:0] faults_r
);
  // Cycles the coil has disagreed with the contacts
  logic [3:0] wait_r;

  // Contacts move only once the coil has held for the switch time
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      contacts_r <= 1'b0;
      wait_r <= 4'h0;
    end
    else if (coil == contacts_r)
      wait_r <= 4'h0;
    else if (wait_r == 4'(SWITCH_CYCLES))
      contacts_r <= coil;
    else
      wait_r <= wait_r + 4'h1;
  end

  // Power on an open motor lead burns the contacts, so count it
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      faults_r <= 8'h00;
    else if (watch && power_release && !contacts_r)
      faults_r <= faults_r + 8'h01;
  end
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps
// Sequence of output function checks around the contactor block
module testbench;
  logic core_clk;
  logic rstn;
  logic [3:0][5:0] sel;
  logic [15:0] cams;
  logic brake_one_inverted;
  logic brake_two_inverted;
  drive_output_pkg::drive_values_type dv;
  drive_output_pkg::limit_params_type lp;
  logic [15:0] win;
  logic [31:0] pwin;
  logic [10:0] dly;
  logic start;
  logic tune;
  logic oc_det;
  logic oc_clr;
  logic hw_rel;
  logic watch;
  logic [3:0] dout;
  logic lim;
  logic reached;
  logic cw;
  logic ccw;
  logic cont;
  logic prel;
  logic oc_err;
  logic contacts;
  logic [7:0] faults;
  int n_errors;
  int compares;

  // Short millisecond keeps the contactor delays cheap to simulate
  drive_output_function_contactor #(.CYCLES_PER_MS(4)) DUT (
    .core_clk(core_clk),
    .rstn(rstn),
    .output_function_selector(sel),
    .cam_points(cams),
    .brake_one(brake_one_inverted),
    .brake_two(brake_two_inverted),
    .drive_values(dv),
    .limit_params(lp),
    .reached_window(win),
    .reached_window_positioning(pwin),
    .contactor_delay(dly),
    .start_request(start),
    .autotune_active(tune),
    .overcurrent_detect(oc_det),
    .overcurrent_clear(oc_clr),
    .hardware_power_release(hw_rel),
    .digital_outputs(dout),
    .limit_flag_r(lim),
    .setpoint_reached_r(reached),
    .clockwise_rotation_r(cw),
    .anticlockwise_rotation_r(ccw),
    .contactor_closed_r(cont),
    .power_stage_release_r(prel),
    .overcurrent_error_one_r(oc_err)
  );

  // Far-side contactor watching the release order
  contactor_model partner (
    .core_clk(core_clk),
    .rstn(rstn),
    .coil(cont),
    .power_release(prel),
    .watch(watch),
    .contacts_r(contacts),
    .faults_r(faults)
  );

  // 25 MHz clock
  always #20 core_clk = ~core_clk;

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Wait n edges, then sample at the falling edge where all is settled
  task automatic look(input int n);
    tick(n);
    @(negedge core_clk);
  endtask

  task automatic chk(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask

  task automatic finish_test();
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Actual values against fixed references and windows
  task automatic act_case(input drive_output_pkg::control_mode_type m,
    input logic signed [15:0] ta, input logic signed [15:0] sa,
    input logic signed [31:0] pa, input logic e);
    tick(1);
    dv.mode <= m;
    dv.torque_act <= ta;
    dv.speed_act <= sa;
    dv.position_act <= pa;
    look(3);
    chk(reached, e, "reached flag");
    chk(dout[0], e, "reached output");
    chk(dout[1], sa > 16'sh000A, "clockwise output");
    chk(dout[2], sa < -16'sh000A, "anticlockwise output");
    chk(cw, sa > 16'sh000A, "clockwise");
    chk(ccw, sa < -16'sh000A, "anticlockwise");
  endtask

  // References against max torque 1000 and max speed 1500
  task automatic lim_case(input drive_output_pkg::control_mode_type m,
    input logic signed [15:0] t, input logic signed [15:0] s,
    input logic e);
    tick(1);
    dv.mode <= m;
    dv.torque_ref <= t;
    dv.speed_ref <= s;
    look(3);
    chk(lim, e, "limit flag");
    chk(dout[3], e, "limit output");
  endtask

  // One start and stop, timing both the making and the breaking delay
  task automatic make_cycle(input logic [10:0] d, input int lo,
    input int hi);
    int cnt;
    tick(1);
    dly <= d;
    look(3);
    tick(1);
    start <= 1'b1;
    look(2);
    chk(cont, 1'b1, "contactor closed");
    chk(dout[1], 1'b1, "contactor output");
    chk(dout[2], 1'b0, "inverted output");
    cnt = 2;
    while (prel !== 1'b1 && cnt < hi + 10)
    begin
      look(1);
      cnt++;
    end
    chk(cnt >= lo && cnt <= hi, 1'b1, "making delay");
    tick(1);
    start <= 1'b0;
    look(1);
    chk(prel, 1'b0, "release drops");
    chk(cont, 1'b1, "contactor held");
    cnt = 1;
    while (cont !== 1'b0 && cnt < hi + 10)
    begin
      look(1);
      cnt++;
    end
    chk(cnt >= lo - 2 && cnt <= hi, 1'b1, "breaking delay");
    chk(dout[2], 1'b1, "inverted idle");
  endtask

  // Cuts a hang short
  initial
  begin
    #(40 * 40000);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end

  initial
  begin
    core_clk = 1'b0;
    rstn = 1'b0;
    sel = '0;
    cams = 16'h0000;
    brake_one_inverted = 1'b0;
    brake_two_inverted = 1'b0;
    dv = '0;
    dv.torque_ref = 16'sh0064;
    dv.speed_ref = 16'sh00C8;
    dv.position_target = 32'sh00001388;
    lp = '0;
    lp.torque_scale = 9'h100;
    lp.torque_limit_factor = 9'h100;
    lp.max_speed_factor = 9'h080;
    lp.rated_motor_torque = 16'h03E8;
    lp.rated_motor_speed = 16'h0BB8;
    win = 16'h000A;
    pwin = 32'h00000014;
    dly = drive_output_pkg::DELAY_DEFAULT_MS;
    start = 1'b0;
    tune = 1'b0;
    oc_det = 1'b0;
    oc_clr = 1'b0;
    hw_rel = 1'b1;
    watch = 1'b0;
    n_errors = 0;
    compares = 0;
    tick(5);
    rstn <= 1'b1;
    // Each cam selector shows exactly its own point
    for (int k = 0; k < 13; k++)
    begin
      tick(1);
      sel[0] <= drive_output_pkg::SEL_CAM_FIRST + 6'(k);
      cams <= 16'h0001 << (k + 3);
      look(3);
      chk(dout[0], 1'b1, "cam on");
      tick(1);
      cams <= ~(16'h0001 << (k + 3));
      look(3);
      chk(dout[0], 1'b0, "cam off");
    end
    // All four brake combinations through the inverted selectors
    for (int b = 0; b < 4; b++)
    begin
      tick(1);
      sel[1] <= drive_output_pkg::SEL_BRAKE_ONE_INV;
      sel[2] <= drive_output_pkg::SEL_BRAKE_TWO_INV;
      brake_one_inverted <= b[0];
      brake_two_inverted <= b[1];
      look(3);
      chk(dout[1], !b[0], "brake one");
      chk(dout[2], !b[1], "brake two");
    end
    tick(1);
    sel[0] <= drive_output_pkg::SEL_REACHED;
    sel[1] <= drive_output_pkg::SEL_ROT_CW;
    sel[2] <= drive_output_pkg::SEL_ROT_CCW;
    sel[3] <= drive_output_pkg::SEL_LIMIT;
    act_case(drive_output_pkg::mode_torque, 16'sh006E, 16'sh0000, 32'sh0, 1'b1);
    act_case(drive_output_pkg::mode_torque, 16'sh006F, 16'sh0000, 32'sh0, 1'b0);
    act_case(drive_output_pkg::mode_speed, 16'sh0, 16'sh00BE, 32'sh0, 1'b1);
    act_case(drive_output_pkg::mode_speed, 16'sh0, 16'sh00BD, 32'sh0, 1'b0);
    act_case(drive_output_pkg::mode_endless, 16'sh0, 16'sh00D2, 32'sh0, 1'b1);
    act_case(drive_output_pkg::mode_endless, 16'sh0, 16'sh00D3, 32'sh0, 1'b0);
    act_case(drive_output_pkg::mode_position, 16'sh0, 16'sh00C8, 32'sh1374, 1'b1);
    act_case(drive_output_pkg::mode_position, 16'sh0, 16'sh00C8, 32'sh1373, 1'b0);
    act_case(drive_output_pkg::mode_speed, 16'sh0, 16'shFFF5, 32'sh0, 1'b0);
    act_case(drive_output_pkg::mode_speed, 16'sh0, 16'shFFF6, 32'sh0, 1'b0);
    lim_case(drive_output_pkg::mode_torque, 16'sh03E9, 16'sh0000, 1'b1);
    lim_case(drive_output_pkg::mode_torque, 16'sh03E8, 16'sh1388, 1'b0);
    lim_case(drive_output_pkg::mode_speed, 16'sh0000, 16'sh05DD, 1'b1);
    lim_case(drive_output_pkg::mode_speed, 16'sh1388, 16'sh05DC, 1'b0);
    lim_case(drive_output_pkg::mode_position, 16'sh03E9, 16'sh0000, 1'b1);
    lim_case(drive_output_pkg::mode_position, 16'sh0000, 16'sh05DD, 1'b1);
    lim_case(drive_output_pkg::mode_position, 16'sh03E8, 16'sh05DC, 1'b0);
    // Contactor sequencing with the partner watching the order
    tick(1);
    sel[1] <= drive_output_pkg::SEL_CONTACTOR;
    sel[2] <= drive_output_pkg::SEL_CONTACTOR_INV;
    watch <= 1'b1;
    make_cycle(11'h003, 12, 17);
    make_cycle(11'h7FF, 8000, 8006);
    chk(faults === 8'h00, 1'b1, "release on open contacts");
    // Self-setting closes the contactor too
    tick(1);
    dly <= 11'h003;
    tune <= 1'b1;
    look(2);
    chk(cont, 1'b1, "contactor in self-setting");
    tick(1);
    tune <= 1'b0;
    watch <= 1'b0;
    dly <= drive_output_pkg::DELAY_OFF_MS;
    look(30);
    // Zero delay: release follows demand, contactor left open
    tick(1);
    start <= 1'b1;
    look(2);
    chk(prel, 1'b1, "release without delay");
    chk(cont, 1'b0, "contactor idle");
    tick(1);
    start <= 1'b0;
    dly <= 11'h003;
    sel[1] <= drive_output_pkg::SEL_BRAKE_ONE_INV;
    sel[2] <= drive_output_pkg::SEL_BRAKE_TWO_INV;
    look(3);
    // No contactor selector anywhere: control stays off
    tick(1);
    start <= 1'b1;
    look(2);
    chk(cont, 1'b0, "no selector, open");
    chk(prel, 1'b1, "no selector, release");
    tick(1);
    start <= 1'b0;
    // Overcurrent with and without the hardware release
    tick(1);
    oc_det <= 1'b1;
    tick(1);
    oc_det <= 1'b0;
    look(2);
    chk(oc_err, 1'b1, "overcurrent raised");
    tick(1);
    oc_clr <= 1'b1;
    tick(1);
    oc_clr <= 1'b0;
    hw_rel <= 1'b0;
    look(6);
    chk(oc_err, 1'b0, "overcurrent cleared");
    tick(1);
    oc_det <= 1'b1;
    tick(1);
    oc_det <= 1'b0;
    look(2);
    chk(oc_err, 1'b0, "overcurrent suppressed");
    finish_test();
  end
endmodule
